// >>> pbo_pkg.sv
// Shared constants and carriers for the port B override and port A bank.
// Assumes a Wishbone classic master with 32-bit data and byte addresses.
package pbo_pkg;

    // ********************************
    // Register map (word indexes)
    // ********************************
    localparam logic [5:0] PBO_IDX_PORT_A_INPUT_LEVELS = 6'h19;
    localparam logic [5:0] PBO_IDX_PORT_A_DIRECTION = 6'h1a;
    localparam logic [5:0] PBO_IDX_PORT_A_OUTPUT_LATCH = 6'h1b;
    localparam logic [5:0] PBO_IDX_MCU_CONTROL = 6'h1c;

    // ********************************
    // Control register fields
    // ********************************
    localparam int PBO_BIT_PULLUP_GLOBAL_DISABLE = 6;
    localparam int PBO_BIT_SLEEP_ENABLE = 5;
    localparam int PBO_BIT_SLEEP_SEL_HI = 4;
    localparam int PBO_BIT_SLEEP_SEL_LO = 3;
    localparam int PBO_BIT_RSV_HI = 7;
    localparam int PBO_BIT_RSV_LO = 2;
    localparam logic [7:0] PBO_MCU_WRITE_MASK = 8'h78;

    // ********************************
    // Reset values
    // ********************************
    localparam logic [7:0] PBO_RST_PORT_A_DIRECTION = 8'h00;
    localparam logic [7:0] PBO_RST_PORT_A_OUTPUT_LATCH = 8'h00;
    localparam logic [7:0] PBO_RST_MCU_CONTROL = 8'h00;

    // ********************************
    // Carriers
    // ********************************
    // Override set for one pin
    typedef struct packed {
        logic pullup_override_en;
        logic pullup_override_val;
        logic dir_override_en;
        logic dir_override_val;
        logic out_override_en;
        logic out_override_val;
        logic input_en_override_en;
        logic input_en_override_val;
    } pbo_ovr_s;

    // Static chip configuration straps, fuses read as programmed = 0
    typedef struct packed {
        logic sysclk_out_fuse;
        logic reset_pin_disable;
        logic debug_enable_fuse;
        logic lock_bits_unprogrammed;
        logic crystal_selected;
        logic selected_a;
    } pbo_cfg_s;

    // Alternate function requests for port B
    typedef struct packed {
        logic [3:0] pin_change_src_en;
        logic pin_change_group1_enable;
        logic ext_irq_zero_en;
        logic timer0_match_a_en;
        logic timer0_match_a_out;
        logic debug_tx;
        logic power_down_state;
    } pbo_alt_s;

endpackage

// >>> pbo_port_mux.sv
// Port B override logic and the port A register bank behind Wishbone.
// Assumes port B latch and direction bits arrive from their own registers.
//
// What this block does
// R1 - PB1 is I/O unless crystal uses it
// R2 - PB1 feeds pin change source nine
// R3 - PB2 carries compare A when direction output
// R4 - Clock out fuse drives clock on PB2
// R5 - PB2 feeds pin change ten and irq0
// R6 - PB3 feeds pin change source eleven
// R7 - Reset role: pull-up on, driver, input off
// R8 - Reset disable high when fuse reads zero
// R9 - Debug mode makes PB3 open-drain with pull-up
// R10 - Debug: pull-up one, out zero, dir=tx
// R11 - Clock out forces PB2 output, pull-up off
// R12 - PB2 input kept on for irq0/pin change
// R13 - Crystal takes PB0 and PB1, values zero
// R14 - External clock takes PB0 only
// R15 - Global pull-up disable kills every pull-up
// R16 - Control bits 7 and 2 read zero
// R17 - Override value wins when enable is high
// R18 - Port A latch/direction full byte, reset zero
//
// Our own choice: register access over Wishbone.
`timescale 1ns/1ps

module pbo_port_mux #(
    parameter int ADDR_W = 8
) (
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [ADDR_W-1:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire pbo_pkg::pbo_cfg_s cfg_i,
    input wire pbo_pkg::pbo_alt_s alt_i,
    input wire logic [3:0] pb_latch_i,
    input wire logic [3:0] pb_dir_i,
    input wire logic [3:0] pb_pin_i,
    output logic [3:0] pb_out_o,
    output logic [3:0] pb_oe_n_o,
    output logic [3:0] pb_pullup_o,
    output logic [3:0] pb_in_en_o,
    output logic [3:0] pb_in_o,
    output logic ext_reset_n_o,
    output logic debug_rx_o,
    input wire logic [7:0] pa_pin_i,
    output logic [7:0] pa_out_o,
    output logic [7:0] pa_oe_n_o,
    output logic [7:0] pa_pullup_o,
    output logic sleep_enable_o,
    output logic [1:0] sleep_mode_o
);

    // ********************************
    // Reset release
    // ********************************
    logic rst_meta_q;
    logic rst_n;

    // Two-stage release of the asynchronous reset
    always_ff @(posedge clock_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rst_meta_q <= 1'b0;
            rst_n <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n <= rst_meta_q;
        end
    end

    // ********************************
    // Helpers
    // ********************************
    // Pick override or register value for one attribute
    function automatic logic pick(input logic en, input logic ov,
                                  input logic reg_val);
        pick = en ? ov : reg_val; // [R17]
    endfunction

    // ********************************
    // Register bank
    // ********************************
    logic [7:0] pa_dir_q;
    logic [7:0] pa_dir_d;
    logic [7:0] pa_latch_q;
    logic [7:0] pa_latch_d;
    logic [7:0] mcu_q;
    logic [7:0] mcu_d;
    logic ack_q;
    logic ack_d;
    logic [31:0] rdat_q;
    logic [31:0] rdat_d;
    logic [5:0] word_idx;
    logic req;
    logic wr_now;
    logic pullup_global_disable;

    assign word_idx = adr_i[7:2];
    assign req = cyc_i & stb_i;
    assign wr_now = req & we_i & ack_q & sel_i[0];
    assign pullup_global_disable = mcu_q[pbo_pkg::PBO_BIT_PULLUP_GLOBAL_DISABLE];

    // Next values of the bank, ack and read data
    always_comb begin
        pa_dir_d = pa_dir_q;
        pa_latch_d = pa_latch_q;
        mcu_d = mcu_q;
        ack_d = req & ~ack_q;
        rdat_d = rdat_q;
        if (wr_now) begin
            if (word_idx == pbo_pkg::PBO_IDX_PORT_A_DIRECTION) begin
                pa_dir_d = dat_i[7:0]; // [R18]
            end else if (word_idx == pbo_pkg::PBO_IDX_PORT_A_OUTPUT_LATCH)
            begin
                pa_latch_d = dat_i[7:0]; // [R18]
            end else if (word_idx == pbo_pkg::PBO_IDX_PORT_A_INPUT_LEVELS)
            begin
                pa_latch_d = pa_latch_q ^ dat_i[7:0];
            end else if (word_idx == pbo_pkg::PBO_IDX_MCU_CONTROL) begin
                mcu_d = dat_i[7:0] & pbo_pkg::PBO_MCU_WRITE_MASK; // [R16]
            end
        end
        if (ack_d && !we_i) begin
            if (word_idx == pbo_pkg::PBO_IDX_PORT_A_INPUT_LEVELS) begin
                rdat_d = {24'h00_0000, pa_pin_i};
            end else if (word_idx == pbo_pkg::PBO_IDX_PORT_A_DIRECTION) begin
                rdat_d = {24'h00_0000, pa_dir_q};
            end else if (word_idx == pbo_pkg::PBO_IDX_PORT_A_OUTPUT_LATCH)
            begin
                rdat_d = {24'h00_0000, pa_latch_q};
            end else if (word_idx == pbo_pkg::PBO_IDX_MCU_CONTROL) begin
                rdat_d = {24'h00_0000,
                          mcu_q & pbo_pkg::PBO_MCU_WRITE_MASK}; // [R16]
            end else begin
                rdat_d = 32'h0000_0000;
            end
        end else if (ack_d) begin
            rdat_d = 32'h0000_0000;
        end
    end

    // Register the bank
    always_ff @(posedge clock_i or negedge rst_n) begin
        if (!rst_n) begin
            pa_dir_q <= pbo_pkg::PBO_RST_PORT_A_DIRECTION; // [R18]
            pa_latch_q <= pbo_pkg::PBO_RST_PORT_A_OUTPUT_LATCH; // [R18]
            mcu_q <= pbo_pkg::PBO_RST_MCU_CONTROL;
            ack_q <= 1'b0;
            rdat_q <= 32'h0000_0000;
        end else begin
            pa_dir_q <= pa_dir_d;
            pa_latch_q <= pa_latch_d;
            mcu_q <= mcu_d;
            ack_q <= ack_d;
            rdat_q <= rdat_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = rdat_q;
    assign sleep_enable_o = mcu_q[pbo_pkg::PBO_BIT_SLEEP_ENABLE];
    assign sleep_mode_o = {mcu_q[pbo_pkg::PBO_BIT_SLEEP_SEL_HI],
                           mcu_q[pbo_pkg::PBO_BIT_SLEEP_SEL_LO]};

    // ********************************
    // Port A pins
    // ********************************
    // Port A drivers and pull-ups straight from the bank
    assign pa_out_o = pa_latch_q;
    assign pa_oe_n_o = ~pa_dir_q;
    assign pa_pullup_o = ~pa_dir_q & pa_latch_q & {8{~pullup_global_disable}}; // [R15]

    // ********************************
    // Port B override terms
    // ********************************
    logic ck_out;
    logic reset_pin_disable;
    logic debug_line_active;
    logic reset_role;
    logic osc;
    logic ext_clk;
    logic [3:0] pc_on;
    pbo_pkg::pbo_ovr_s ovr [4];

    assign ck_out = ~cfg_i.sysclk_out_fuse;
    assign reset_pin_disable = ~cfg_i.reset_pin_disable; // [R8]
    assign debug_line_active = ~cfg_i.debug_enable_fuse
                             & cfg_i.lock_bits_unprogrammed; // [R9]
    assign reset_role = ~reset_pin_disable;
    assign osc = cfg_i.crystal_selected;
    assign ext_clk = cfg_i.selected_a;
    assign pc_on = alt_i.pin_change_src_en
                 & {4{alt_i.pin_change_group1_enable}};

    // Per-pin override sets
    always_comb begin
        // Pin zero: oscillator input or external clock input
        ovr[0].pullup_override_en = ext_clk | osc; // [R13] [R14]
        ovr[0].pullup_override_val = 1'b0;
        ovr[0].dir_override_en = ext_clk | osc; // [R13] [R14]
        ovr[0].dir_override_val = 1'b0;
        ovr[0].out_override_en = ext_clk | osc;
        ovr[0].out_override_val = 1'b0;
        ovr[0].input_en_override_en = ext_clk | osc | pc_on[0];
        ovr[0].input_en_override_val = (ext_clk & alt_i.power_down_state)
                                     | (~ext_clk & ~osc & pc_on[0]);
        // Pin one: oscillator output only with a crystal
        ovr[1].pullup_override_en = osc; // [R1] [R13]
        ovr[1].pullup_override_val = 1'b0;
        ovr[1].dir_override_en = osc; // [R1]
        ovr[1].dir_override_val = 1'b0;
        ovr[1].out_override_en = osc;
        ovr[1].out_override_val = 1'b0;
        ovr[1].input_en_override_en = osc | pc_on[1]; // [R2]
        ovr[1].input_en_override_val = ~osc & pc_on[1]; // [R2]
        // Pin two: clock out, compare A, irq0, pin change ten
        ovr[2].pullup_override_en = ck_out; // [R11]
        ovr[2].pullup_override_val = 1'b0;
        ovr[2].dir_override_en = ck_out; // [R4] [R11]
        ovr[2].dir_override_val = 1'b1;
        ovr[2].out_override_en = ck_out | alt_i.timer0_match_a_en; // [R3]
        ovr[2].out_override_val = ck_out ? clock_i
                                : alt_i.timer0_match_a_out; // [R4]
        ovr[2].input_en_override_en = pc_on[2]
                                    | alt_i.ext_irq_zero_en; // [R12]
        ovr[2].input_en_override_val = pc_on[2]
                                     | alt_i.ext_irq_zero_en; // [R5]
        // Pin three: reset input, debug line, pin change eleven
        ovr[3].pullup_override_en = reset_role | debug_line_active; // [R7]
        ovr[3].pullup_override_val = 1'b1; // [R10]
        ovr[3].dir_override_en = reset_role | debug_line_active;
        ovr[3].dir_override_val = debug_line_active
                                & alt_i.debug_tx; // [R10]
        ovr[3].out_override_en = reset_role | debug_line_active;
        ovr[3].out_override_val = 1'b0; // [R10]
        ovr[3].input_en_override_en = reset_role | debug_line_active
                                    | pc_on[3]; // [R6]
        ovr[3].input_en_override_val = debug_line_active
                                     | (~reset_role & pc_on[3]); // [R7]
    end

    // ********************************
    // Port B pin drive
    // ********************************
    logic [3:0] pb_dir;
    logic [3:0] pb_pu_reg;

    assign pb_pu_reg = ~pb_dir_i & pb_latch_i & {4{~pullup_global_disable}}; // [R15]

    // Apply overrides to every pin attribute
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            pb_dir[i] = pick(ovr[i].dir_override_en,
                             ovr[i].dir_override_val, pb_dir_i[i]);
            pb_out_o[i] = pick(ovr[i].out_override_en,
                               ovr[i].out_override_val, pb_latch_i[i]);
            pb_pullup_o[i] = pick(ovr[i].pullup_override_en,
                                  ovr[i].pullup_override_val & ~pullup_global_disable,
                                  pb_pu_reg[i]); // [R15]
            pb_in_en_o[i] = pick(ovr[i].input_en_override_en,
                                 ovr[i].input_en_override_val, 1'b1);
        end
    end

    assign pb_oe_n_o = ~pb_dir;
    assign pb_in_o = pb_pin_i & pb_in_en_o; // [R2] [R5] [R6]
    assign ext_reset_n_o = reset_role & ~debug_line_active
                         ? pb_pin_i[3] : 1'b1; // [R7]
    assign debug_rx_o = debug_line_active ? pb_pin_i[3] : 1'b1; // [R9]

    // ********************************
    // Checks
    // ********************************
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!rst_n);

    ack_one_cycle_a: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    pud_pullups_off_a: assert property ( // [R15]
        pullup_global_disable |-> (pa_pullup_o == 8'h00) && (pb_pullup_o == 4'h0))
        else $error("pull-up active under global disable");
    sysclk_out_fuse_pin_two_a: assert property ( // [R4]
        ck_out |-> !pb_oe_n_o[2] && !pb_pullup_o[2]
                   && (pb_out_o[2] == clock_i))
        else $error("clock output not on pin two");
    compare_a_drive_a: assert property ( // [R3]
        !ck_out && alt_i.timer0_match_a_en && pb_dir_i[2]
        |-> !pb_oe_n_o[2] && (pb_out_o[2] == alt_i.timer0_match_a_out))
        else $error("compare A not driven on pin two");
    reset_pin_role_a: assert property ( // [R7]
        reset_role && !debug_line_active |-> pb_oe_n_o[3]
        && !pb_in_en_o[3] && (pb_pullup_o[3] == !pullup_global_disable))
        else $error("reset pin not configured");
    reset_fuse_a: assert property ( // [R8]
        !cfg_i.reset_pin_disable && !debug_line_active
        |-> ext_reset_n_o && (pb_oe_n_o[3] == !pb_dir_i[3]))
        else $error("reset role active with fuse programmed");
    debug_line_a: assert property ( // [R10]
        debug_line_active |-> !pb_out_o[3]
        && (pb_oe_n_o[3] == !alt_i.debug_tx) && pb_in_en_o[3])
        else $error("debug line drive wrong");
    osc_pins_a: assert property ( // [R13]
        osc |-> (pb_oe_n_o[1:0] == 2'b11) && (pb_pullup_o[1:0] == 2'b00)
        && !pb_in_en_o[1])
        else $error("oscillator pins not released");
    selected_a_pins_a: assert property ( // [R14]
        ext_clk && !osc |-> pb_oe_n_o[0]
        && (pb_oe_n_o[1] == !pb_dir_i[1]))
        else $error("external clock pin handling wrong");
    irq_input_en_a: assert property ( // [R12]
        alt_i.ext_irq_zero_en || pc_on[2] |-> pb_in_en_o[2]
        && (pb_in_o[2] == pb_pin_i[2]))
        else $error("pin two input disabled");
    pin_change_nine_a: assert property ( // [R2]
        !osc && pc_on[1] |-> pb_in_o[1] == pb_pin_i[1])
        else $error("pin change nine lost");
    pin_change_eleven_a: assert property ( // [R6]
        !reset_role && !debug_line_active && pc_on[3]
        |-> pb_in_o[3] == pb_pin_i[3])
        else $error("pin change eleven lost");
    latch_write_a: assert property ( // [R18]
        wr_now && (word_idx == pbo_pkg::PBO_IDX_PORT_A_OUTPUT_LATCH)
        |=> pa_out_o == $past(dat_i[7:0]))
        else $error("port A latch write lost");
    reserved_zero_a: assert property ( // [R16]
        req && !we_i && ack_d
        && (word_idx == pbo_pkg::PBO_IDX_MCU_CONTROL)
        |=> ack_o && !dat_o[7] && !dat_o[2])
        else $error("reserved control bit reads one");

    // Writes reach the port A drivers and the sleep enable output; each request is acked in one cycle
    dir_write_a: assert property ( // [R18]
        wr_now && (word_idx == pbo_pkg::PBO_IDX_PORT_A_DIRECTION)
        |=> pa_oe_n_o == ~$past(dat_i[7:0]))
        else $error("port A direction write lost");
    sleep_bits_a: assert property (
        wr_now && (word_idx == pbo_pkg::PBO_IDX_MCU_CONTROL)
        |=> sleep_enable_o == $past(dat_i[pbo_pkg::PBO_BIT_SLEEP_ENABLE]))
        else $error("sleep enable write lost");
    ack_answer_a: assert property (req && !ack_o |=> ack_o)
        else $error("request not answered in one cycle");

    // Register values reach pins that no alternate function claims
    pin_one_io_a: assert property ( // [R1]
        !osc |-> (pb_oe_n_o[1] == !pb_dir_i[1])
        && (pb_out_o[1] == pb_latch_i[1]))
        else $error("pin one not an ordinary I/O pin");
    pin_two_plain_a: assert property ( // [R17]
        !ck_out && !alt_i.timer0_match_a_en
        |-> (pb_out_o[2] == pb_latch_i[2])
        && (pb_oe_n_o[2] == !pb_dir_i[2]))
        else $error("pin two ignores its registers");
    pin_zero_pullup_a: assert property ( // [R15]
        !osc && !ext_clk |-> pb_pullup_o[0]
        == (!pb_dir_i[0] && pb_latch_i[0] && !pullup_global_disable))
        else $error("pin zero pull-up wrong");

    // ********************************
    // Covers
    // ********************************
    sysclk_out_fuse_seen_c: cover property (ck_out && alt_i.timer0_match_a_en);
    reset_pin_c: cover property (reset_role && !debug_line_active
        && !pb_pin_i[3]);
    debug_tx_c: cover property (debug_line_active && alt_i.debug_tx);
    latch_write_c: cover property (wr_now
        && (word_idx == pbo_pkg::PBO_IDX_PORT_A_OUTPUT_LATCH));
    pud_read_c: cover property (pullup_global_disable && ack_o && !we_i);

endmodule

// >>> pbo_pin_model.sv
// Behavioural pins around port B: device driver, outside drive, pull-ups.
// Assumes the bench sets the outside drive; undriven pins wander.
`timescale 1ns/1ps

module pbo_pin_model (
    input wire logic clock_i,
    input wire logic [3:0] pb_out_i,
    input wire logic [3:0] pb_oe_n_i,
    input wire logic [3:0] pb_pullup_i,
    input wire logic [3:0] ext_en_i,
    input wire logic [3:0] ext_val_i,
    output logic [3:0] pb_pin_o
);
    // ********************************
    // Pin resolution
    // ********************************
    logic [3:0] float_q = 4'h5;

    // Floating pins flip every cycle so no stale level survives
    always_ff @(posedge clock_i) begin
        float_q <= ~float_q;
    end

    // Device driver first, then outside drive, then pull-up
    always_comb begin
        for (int i = 0; i < 4; i++) begin
            if (!pb_oe_n_i[i]) begin
                pb_pin_o[i] = pb_out_i[i];
            end else if (ext_en_i[i]) begin
                pb_pin_o[i] = ext_val_i[i];
            end else if (pb_pullup_i[i]) begin
                pb_pin_o[i] = 1'b1;
            end else begin
                pb_pin_o[i] = float_q[i];
            end
        end
    end
endmodule

// >>> test_port_b_override_and_port_a_regs.sv
// Self-checking bench for the port B overrides and port A registers.
// Assumes pbo_pkg, pbo_port_mux and pbo_pin_model are compiled first.
`timescale 1ns/1ps

module test_port_b_override_and_port_a_regs;
    // ********************************
    // Stimulus, model and checks
    // ********************************
    localparam logic [7:0] A_PIN =
        {pbo_pkg::PBO_IDX_PORT_A_INPUT_LEVELS, 2'b00};
    localparam logic [7:0] A_DIR = {pbo_pkg::PBO_IDX_PORT_A_DIRECTION, 2'b00};
    localparam logic [7:0] A_LAT =
        {pbo_pkg::PBO_IDX_PORT_A_OUTPUT_LATCH, 2'b00};
    localparam logic [7:0] A_MCU = {pbo_pkg::PBO_IDX_MCU_CONTROL, 2'b00};
    logic clock_i = 1'b0;
    logic rst_n_i = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [7:0] pa_pin = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [3:0] lat = 4'h0;
    logic [3:0] dir = 4'h0;
    logic [3:0] ext_en = 4'h0;
    logic [3:0] ext_val = 4'h0;
    logic [31:0] dat = 32'h0000_0000;
    logic [31:0] seed = 32'h0000_35bd;
    pbo_pkg::pbo_cfg_s cfg = 6'h18;
    pbo_pkg::pbo_alt_s alt = '0;
    logic [7:0] e_dir = 8'h00;
    logic [7:0] e_lat = 8'h00;
    logic [7:0] e_mcu = 8'h00;
    logic [31:0] dat_o;
    logic ack_o, ext_reset_n_o, debug_rx_o, sleep_enable_o;
    logic [1:0] sleep_mode_o;
    logic [3:0] pb_out_o, pb_oe_n_o, pb_pullup_o, pb_in_en_o, pb_in_o, pb_pin;
    logic [7:0] pa_out_o, pa_oe_n_o, pa_pullup_o;
    int num_errors = 0;
    int num_checks = 0;

    // Design and the pins around it
    pbo_port_mux #(.ADDR_W(8)) i_dut (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel),
        .dat_i(dat), .dat_o(dat_o), .ack_o(ack_o), .cfg_i(cfg), .alt_i(alt),
        .pb_latch_i(lat), .pb_dir_i(dir), .pb_pin_i(pb_pin),
        .pb_out_o(pb_out_o), .pb_oe_n_o(pb_oe_n_o), .pb_pullup_o(pb_pullup_o),
        .pb_in_en_o(pb_in_en_o), .pb_in_o(pb_in_o),
        .ext_reset_n_o(ext_reset_n_o), .debug_rx_o(debug_rx_o),
        .pa_pin_i(pa_pin), .pa_out_o(pa_out_o), .pa_oe_n_o(pa_oe_n_o),
        .pa_pullup_o(pa_pullup_o), .sleep_enable_o(sleep_enable_o),
        .sleep_mode_o(sleep_mode_o));
    pbo_pin_model i_pins (.clock_i(clock_i), .pb_out_i(pb_out_o),
        .pb_oe_n_i(pb_oe_n_o), .pb_pullup_i(pb_pullup_o), .ext_en_i(ext_en),
        .ext_val_i(ext_val), .pb_pin_o(pb_pin));

    // 100 MHz clock
    initial begin
        forever #5 clock_i = ~clock_i;
    end

    // Xorshift source
    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    // Expected port B view: mode flags, out, oe_n, pull-up, input enable
    function automatic logic [17:0] exp_pb();
        logic [3:0] o, oe, pu, ie;
        logic dbg, rr;
        dbg = ~cfg.debug_enable_fuse & cfg.lock_bits_unprogrammed;
        rr = cfg.reset_pin_disable & ~dbg;
        o = lat;
        oe = ~dir;
        pu = ~dir & lat;
        ie = 4'hf;
        if (cfg.crystal_selected | cfg.selected_a) begin
            {o[0], oe[0], pu[0]} = 3'h2;
            ie[0] = cfg.selected_a & alt.power_down_state;
        end
        if (cfg.crystal_selected) begin
            {o[1], oe[1], pu[1], ie[1]} = 4'h4;
        end
        if (!cfg.sysclk_out_fuse) begin
            {o[2], oe[2], pu[2]} = {clock_i, 2'h0};
        end else if (alt.timer0_match_a_en) begin
            o[2] = alt.timer0_match_a_out;
        end
        if (dbg) begin
            {o[3], oe[3], pu[3], ie[3]} = {1'b0, ~alt.debug_tx, 2'h3};
        end else if (rr) begin
            {o[3], oe[3], pu[3], ie[3]} = 4'h6;
        end
        if (e_mcu[6]) begin
            pu = 4'h0;
        end
        return {dbg, rr, o, oe, pu, ie};
    endfunction

    // Compare tasks
    task automatic check_bus(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic check_pin(input logic [15:0] got, input logic [15:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic finish_test();
        $display("checks=%0d errors=%0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    // One classic Wishbone cycle, bounded wait for ack
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [3:0] s, output logic [31:0] q);
        int n;
        @(posedge clock_i);
        {cyc, stb, we, adr, dat, sel} <= {2'h3, w, a, d, s};
        n = 0;
        do begin
            @(posedge clock_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (n >= 50) begin
            check_bus({31'h0, ack_o}, 32'h0000_0001);
            finish_test();
        end else begin
            q = dat_o;
            {cyc, stb, we} <= 3'h0;
        end
    endtask

    // Read back the bank and compare the port A pins
    task automatic check_regs();
        logic [31:0] r;
        wb(1'b0, A_DIR, 32'h0000_0000, 4'hf, r);
        check_bus(r, {24'h0, e_dir});
        wb(1'b0, A_LAT, 32'h0000_0000, 4'hf, r);
        check_bus(r, {24'h0, e_lat});
        wb(1'b0, A_MCU, 32'h0000_0000, 4'hf, r);
        check_bus(r, {24'h0, e_mcu});
        check_bus({pa_out_o, pa_oe_n_o, pa_pullup_o, sleep_enable_o,
            sleep_mode_o, 5'h0}, {e_lat, ~e_dir, ~e_dir & e_lat
            & {8{~e_mcu[6]}}, e_mcu[5:3], 5'h0});
    endtask

    // Port B pins, a moment after the falling edge
    task automatic check_pb();
        logic [17:0] e;
        logic [15:0] g;
        logic [15:0] x;
        #1;
        e = exp_pb();
        g = {pb_out_o, pb_oe_n_o, pb_pullup_o, pb_in_en_o};
        check_pin(g, e[15:0]);
        // Debug receive, then reset input, each idle high when not in role
        g = {pb_in_o, debug_rx_o, ext_reset_n_o, 10'h000};
        x = {pb_pin & e[3:0], (e[17:16] & {2{pb_pin[3]}}) | ~e[17:16],
            10'h000};
        check_pin(g, x);
    endtask

    // Main sequence
    initial begin
        logic [31:0] d;
        logic [31:0] q;
        repeat (16) begin
            @(negedge clock_i);
            check_pb();
        end
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        check_regs();
        wb(1'b1, A_MCU, 32'hffff_ffff, 4'hf, q);
        e_mcu = 8'h78;
        check_regs();
        wb(1'b1, A_LAT, 32'h0000_00ff, 4'he, q);
        check_regs();
        wb(1'b1, 8'h74, 32'h0000_00ff, 4'hf, q);
        wb(1'b0, 8'h74, 32'h0000_0000, 4'hf, q);
        check_bus(q, 32'h0000_0000);
        for (int i = 0; i < 150; i++) begin
            @(posedge clock_i);
            d = xs();
            // First two passes: debug line, transmitting then idle
            if (i < 2) begin
                d[23:18] = 6'h34;
                d[9] = ~i[0];
            end
            {cfg, alt, lat, dir} <= d[23:0];
            d = xs();
            if (i < 2) begin
                d[15:8] = {~i[0], 7'h00};
            end
            {ext_en, ext_val, pa_pin} <= d[15:0];
            d = xs();
            wb(1'b1, A_DIR, d, 4'hf, q);
            e_dir = d[7:0];
            d = xs();
            wb(1'b1, A_LAT, d, 4'hf, q);
            e_lat = d[7:0];
            d = xs();
            wb(1'b1, A_PIN, d, 4'hf, q);
            e_lat = e_lat ^ d[7:0];
            d = xs();
            wb(1'b1, A_MCU, d, 4'hf, q);
            e_mcu = d[7:0] & 8'h78;
            check_regs();
            wb(1'b0, A_PIN, 32'h0000_0000, 4'hf, q);
            check_bus(q, {24'h0, pa_pin});
            @(negedge clock_i);
            check_pb();
        end
        // Mid-run reset: bank clears, port B pins keep working
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        {e_dir, e_lat, e_mcu} = 24'h00_0000;
        repeat (4) begin
            @(negedge clock_i);
            check_pb();
        end
        @(posedge clock_i);
        rst_n_i <= 1'b1;
        repeat (3) @(posedge clock_i);
        check_regs();
        finish_test();
    end
endmodule
